// [hdl/emac_status.sv]
// ethernet descriptor status, interrupt flags and shared-memory partition registers
// assumes the mac/dma raise one-cycle event pulses on core_clk and an avalon-mm master
//
// Functional notes
// [RULE_01] transmit state machine fault sets flag seven
// [RULE_02] phy management exchange sets flag six
// [RULE_03] overrun sets flag two, drop packets until cleared
// [RULE_04] control frame sent sets one, packet sent zero
// [RULE_05] rx control five, pause four, done three
// [RULE_06] three pointers split tx and rx regions
// [RULE_07] packet buffers 32 to 256 bytes, bits 7:6
// [RULE_08] descriptor first, then frame, spanning buffers
// [RULE_09] descriptor: next pointer, size, status word
// [RULE_10] size counts fcs, excludes seven descriptor bytes
// [RULE_11] status bit fifteen: zero host, one mac
// [RULE_12] bit fourteen aborted, thirteen back pressure
// [RULE_13] bit twelve when size exceeds maximum
// [RULE_14] bit eleven when length field above 1518
// [RULE_15] bit ten when length field disagrees
// [RULE_16] bit nine bad fcs without append
// [RULE_17] bit eight deferred, seven excessive deferral
// [RULE_18] bit six underrun, abort tells retry
// [RULE_19] bit five late collision beyond threshold
// [RULE_20] bits 3:0 collisions, bit four over limit
// [RULE_21] final status written back, ownership cleared
// [RULE_22] flags sticky until cleared, irq while any
`timescale 1ns/1ns

module emac_status (
  // clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // avalon-mm slave
  input wire logic [emac_status_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // mac event pulses
  input wire emac_status_pkg::mac_events_t mac_events,
  // transmit attempt
  input wire logic tx_start,
  input wire emac_status_pkg::tx_frame_t tx_frame,
  input wire logic tx_defer_tick,
  input wire logic tx_backpressure,
  input wire logic tx_underrun,
  input wire logic tx_collision,
  input wire logic [15:0] tx_byte_count,
  input wire logic tx_complete,
  // transmit decisions and descriptor write-back
  output logic tx_retry,
  output logic tx_abort,
  output logic tx_soft_reset,
  output emac_status_pkg::desc_wb_t desc_wb,
  // partition and receive gating
  output logic [23:0] transmit_region_start,
  output logic [23:0] receive_region_start,
  output logic [23:0] receive_region_limit,
  output logic [8:0] pkt_buf_bytes,
  output logic fcs_append_enable,
  output logic rx_discard,
  output logic irq
);
  import emac_status_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic [7:0] irq_status;
    logic [23:0] tx_lo;
    logic [23:0] rx_lo;
    logic [23:0] rx_hi;
    logic [7:0] buf_size;
    logic [15:0] max_frame;
    logic [7:0] cfg_two;
    logic [7:0] cfg_three;
    logic [7:0] control;
    logic [15:0] tx_stat;
    logic [23:0] next_ptr;
    logic is_ctrl;
    logic [14:0] defer_cnt;
    logic [4:0] col_cnt;
    logic tx_busy;
    logic retry;
    logic abort;
    logic soft_reset;
    desc_wb_t wb;
    logic [8:0] buf_bytes;
    logic discard;
    logic irq;
  } state_t;

  state_t st_q;
  state_t st_d;

  // byte-lane merge for a write of up to 32 bits
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  logic wr_go;
  logic rd_go;
  logic [31:0] rd_mux;
  logic [31:0] wr_val;
  logic [7:0] irq_clear;
  logic [7:0] irq_set;
  logic [14:0] defer_limit;
  logic [4:0] col_next;
  logic [15:0] stat_w;
  logic finish;
  logic late;

  // the ack cycle is the only one with waitrequest low, so every access takes two edges
  assign wr_go = avs_write && st_q.ack;
  assign rd_go = avs_read && !st_q.ack;

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address == OFS_IRQ_STATUS) begin
      rd_mux = {24'h00_0000, st_q.irq_status};
    end else if (avs_address == OFS_TX_START) begin
      rd_mux = {8'h00, st_q.tx_lo};
    end else if (avs_address == OFS_RX_START) begin
      rd_mux = {8'h00, st_q.rx_lo};
    end else if (avs_address == OFS_RX_LIMIT) begin
      rd_mux = {8'h00, st_q.rx_hi};
    end else if (avs_address == OFS_BUF_SIZE) begin
      rd_mux = {24'h00_0000, st_q.buf_size};
    end else if (avs_address == OFS_MAX_FRAME) begin
      rd_mux = {16'h0000, st_q.max_frame};
    end else if (avs_address == OFS_CFG_TWO) begin
      rd_mux = {24'h00_0000, st_q.cfg_two};
    end else if (avs_address == OFS_CFG_THREE) begin
      rd_mux = {24'h00_0000, st_q.cfg_three};
    end else if (avs_address == OFS_CONTROL) begin
      rd_mux = {24'h00_0000, st_q.control};
    end else if (avs_address == OFS_TX_STATUS) begin
      rd_mux = {16'h0000, st_q.tx_stat};
    end
  end

  always_comb begin
    wr_val = 32'h0000_0000;
    irq_clear = 8'h00;
    irq_set = 8'h00;
    stat_w = 16'h0000;
    finish = 1'b0;
    late = 1'b0;
    col_next = 5'h00;
    defer_limit = st_q.control[CTL_SPEED_100] ? XS_DEFER_NIBBLES : XS_DEFER_BITS;
    st_d = st_q;
    st_d.ack = (avs_read || avs_write) && !st_q.ack;
    st_d.retry = 1'b0;
    st_d.abort = 1'b0;
    st_d.soft_reset = 1'b0;
    st_d.wb.valid = 1'b0;
    if (rd_go) begin
      st_d.rdata = rd_mux;
    end

    // register writes
    if (wr_go) begin
      wr_val = lane_merge(rd_mux, avs_writedata, avs_byteenable);
      if (avs_address == OFS_IRQ_STATUS) begin
        irq_clear = avs_byteenable[0] ? avs_writedata[7:0] : 8'h00;
      end else if (avs_address == OFS_TX_START) begin
        st_d.tx_lo = wr_val[23:0]; // RULE_06
      end else if (avs_address == OFS_RX_START) begin
        st_d.rx_lo = wr_val[23:0]; // RULE_06
      end else if (avs_address == OFS_RX_LIMIT) begin
        st_d.rx_hi = wr_val[23:0]; // RULE_06
      end else if (avs_address == OFS_BUF_SIZE) begin
        st_d.buf_size = wr_val[7:0];
      end else if (avs_address == OFS_MAX_FRAME) begin
        st_d.max_frame = wr_val[15:0];
      end else if (avs_address == OFS_CFG_TWO) begin
        st_d.cfg_two = wr_val[7:0];
      end else if (avs_address == OFS_CFG_THREE) begin
        st_d.cfg_three = wr_val[7:0];
      end else if (avs_address == OFS_CONTROL) begin
        st_d.control = {5'h00, wr_val[2:0]};
        st_d.soft_reset = wr_val[CTL_TX_RESET]; // RULE_01
      end
    end
    // size follows the two top bits of the buffer-size setting
    st_d.buf_bytes = BUF_UNIT_BYTES << st_q.buf_size[7:6]; // RULE_07

    // transmit status accumulation
    if (st_q.soft_reset) begin
      st_d.tx_busy = 1'b0;
      st_d.tx_stat = 16'h0000;
    end else if (tx_start) begin
      st_d.tx_busy = 1'b1;
      st_d.next_ptr = tx_frame.next_ptr; // RULE_09
      st_d.is_ctrl = tx_frame.is_ctrl;
      st_d.defer_cnt = 15'h0000;
      st_d.col_cnt = 5'h00;
      st_d.tx_stat = 16'h0000;
      st_d.tx_stat[TS_OWNER] = 1'b1; // RULE_11
      // size already holds the fcs bytes and never the descriptor bytes
      st_d.tx_stat[TS_HUGE] = tx_frame.pkt_size > st_q.max_frame; // RULE_10 RULE_13
      st_d.tx_stat[TS_LOOR] = tx_frame.type_len > MAX_LEN_FIELD && tx_frame.type_len < MIN_TYPE_FIELD; // RULE_14
      st_d.tx_stat[TS_LEN_ERR] = tx_frame.type_len <= MAX_LEN_FIELD
                                 && tx_frame.type_len != tx_frame.data_len; // RULE_15
      st_d.tx_stat[TS_BAD_FCS] = !st_q.control[CTL_FCS_APPEND] && !tx_frame.fcs_ok; // RULE_16
    end else if (st_q.tx_busy) begin
      if (tx_backpressure) begin
        st_d.tx_stat[TS_BACKPR] = 1'b1; // RULE_12
      end
      if (tx_defer_tick) begin
        if (st_q.defer_cnt != 15'h7FFF) begin
          st_d.defer_cnt = st_q.defer_cnt + 15'h0001;
        end
        st_d.tx_stat[TS_DEFER] = 1'b1; // RULE_17
        if (st_d.defer_cnt > defer_limit) begin
          st_d.tx_stat[TS_XS_DEFER] = 1'b1; // RULE_17
        end
      end
      if (tx_underrun) begin
        st_d.tx_stat[TS_UNDERRUN] = 1'b1; // RULE_18
        if (st_q.control[CTL_UNDERRUN_RETRY]) begin
          st_d.retry = 1'b1;
        end else begin
          st_d.abort = 1'b1; // RULE_18
        end
      end
      if (tx_collision) begin
        late = tx_byte_count > {10'h000, st_q.cfg_two[5:0]};
        if (late) begin
          st_d.tx_stat[TS_LATE_COL] = 1'b1; // RULE_19
          st_d.abort = 1'b1;
        end else begin
          col_next = st_q.col_cnt == 5'h1F ? 5'h1F : st_q.col_cnt + 5'h01;
          st_d.col_cnt = col_next;
          st_d.tx_stat[3:0] = col_next[4] ? 4'hF : col_next[3:0]; // RULE_20
          if (col_next > {1'b0, st_q.cfg_three[3:0]}) begin
            st_d.tx_stat[TS_MAX_COL] = 1'b1; // RULE_20
            st_d.abort = 1'b1;
          end else begin
            st_d.retry = 1'b1; // RULE_19
          end
        end
      end
      if (st_d.abort) begin
        st_d.retry = 1'b0;
        st_d.tx_stat[TS_ABORT] = 1'b1; // RULE_12
        finish = 1'b1;
      end else if (tx_complete && !st_d.retry) begin
        finish = 1'b1;
        irq_set[st_q.is_ctrl ? IRQ_TX_CTRL : IRQ_TX_DONE] = 1'b1; // RULE_04
      end
      if (finish) begin
        // hand the descriptor back with its final status
        stat_w = st_d.tx_stat;
        stat_w[TS_OWNER] = 1'b0; // RULE_21
        st_d.tx_stat = stat_w;
        st_d.wb = '{valid: 1'b1, next_ptr: st_q.next_ptr, status: stat_w}; // RULE_08 RULE_21
        st_d.tx_busy = 1'b0;
      end
    end

    // system and receive events
    irq_set[IRQ_FSM_FAULT] = mac_events.fsm_fault; // RULE_01
    irq_set[IRQ_MGMT] = mac_events.mgmt_done; // RULE_02
    irq_set[IRQ_RX_OVR] = mac_events.rx_overrun; // RULE_03
    // packets that end while discarding are dropped without a trace
    if (!st_q.discard && !mac_events.rx_overrun) begin
      irq_set[IRQ_RX_DONE] = mac_events.rx_done; // RULE_05
      irq_set[IRQ_RX_CTRL] = mac_events.rx_done && mac_events.rx_ctrl; // RULE_05
      irq_set[IRQ_RX_PAUSE] = mac_events.rx_done && mac_events.rx_pause; // RULE_05
    end
    // a new event beats a clear in the same cycle
    st_d.irq_status = (st_q.irq_status & ~irq_clear) | irq_set; // RULE_22
    st_d.discard = st_d.irq_status[IRQ_RX_OVR]; // RULE_03
    st_d.irq = |st_d.irq_status; // RULE_22
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{ack: 1'b0, rdata: 32'h0000_0000, irq_status: 8'h00, tx_lo: RST_PTR, rx_lo: RST_PTR,
                rx_hi: RST_PTR, buf_size: RST_BUF_SIZE, max_frame: RST_MAX_FRAME, cfg_two: RST_CFG_TWO,
                cfg_three: RST_CFG_THREE, control: RST_CONTROL, tx_stat: 16'h0000, next_ptr: RST_PTR,
                is_ctrl: 1'b0, defer_cnt: 15'h0000, col_cnt: 5'h00, tx_busy: 1'b0, retry: 1'b0,
                abort: 1'b0, soft_reset: 1'b0, wb: '0, buf_bytes: BUF_UNIT_BYTES, discard: 1'b0,
                irq: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  assign avs_readdata = st_q.rdata;
  assign avs_waitrequest = !st_q.ack;
  assign tx_retry = st_q.retry;
  assign tx_abort = st_q.abort;
  assign tx_soft_reset = st_q.soft_reset;
  assign desc_wb = st_q.wb;
  assign transmit_region_start = st_q.tx_lo;
  assign receive_region_start = st_q.rx_lo;
  assign receive_region_limit = st_q.rx_hi;
  assign pkt_buf_bytes = st_q.buf_bytes;
  assign fcs_append_enable = st_q.control[CTL_FCS_APPEND];
  assign rx_discard = st_q.discard;
  assign irq = st_q.irq;

  // checks
  logic status_clear2;
  assign status_clear2 = wr_go && avs_address == OFS_IRQ_STATUS && avs_byteenable[0] && avs_writedata[IRQ_RX_OVR];

  property p_fault_flag;
    @(posedge core_clk) disable iff (!reset_n)
    mac_events.fsm_fault |=> st_q.irq_status[IRQ_FSM_FAULT] && irq;
  endproperty
  a_fault_flag: assert property (p_fault_flag) else $error("fault flag not raised"); // RULE_01

  property p_mgmt_flag;
    @(posedge core_clk) disable iff (!reset_n)
    mac_events.mgmt_done |=> st_q.irq_status[IRQ_MGMT];
  endproperty
  a_mgmt_flag: assert property (p_mgmt_flag) else $error("management flag not raised"); // RULE_02

  property p_discard_hold;
    @(posedge core_clk) disable iff (!reset_n)
    rx_discard && !status_clear2 |=> rx_discard;
  endproperty
  a_discard_hold: assert property (p_discard_hold) else $error("discard dropped without clear"); // RULE_03

  property p_discard_silent;
    @(posedge core_clk) disable iff (!reset_n)
    rx_discard && mac_events.rx_done && !st_q.irq_status[IRQ_RX_DONE] && !status_clear2
      |=> !st_q.irq_status[IRQ_RX_DONE];
  endproperty
  a_discard_silent: assert property (p_discard_silent) else $error("packet accepted during discard"); // RULE_03

  sequence s_plain_done;
    st_q.tx_busy && !st_q.soft_reset && !tx_start && tx_complete && !st_q.is_ctrl
      && !tx_collision && !tx_underrun;
  endsequence
  sequence s_written_back;
    desc_wb.valid && !desc_wb.status[TS_OWNER] && st_q.irq_status[IRQ_TX_DONE] ##1 !desc_wb.valid;
  endsequence
  property p_tx_done;
    @(posedge core_clk) disable iff (!reset_n)
    s_plain_done |=> s_written_back;
  endproperty
  a_tx_done: assert property (p_tx_done) else $error("transmit completion not reported"); // RULE_04

  property p_rx_done;
    @(posedge core_clk) disable iff (!reset_n)
    mac_events.rx_done && mac_events.rx_pause && !rx_discard && !mac_events.rx_overrun
      |=> st_q.irq_status[IRQ_RX_DONE] && st_q.irq_status[IRQ_RX_PAUSE];
  endproperty
  a_rx_done: assert property (p_rx_done) else $error("receive flags not raised"); // RULE_05

  property p_buf_size;
    @(posedge core_clk) disable iff (!reset_n)
    wr_go && avs_address == OFS_BUF_SIZE && avs_byteenable[0]
      |=> ##1 pkt_buf_bytes == (BUF_UNIT_BYTES << $past(avs_writedata[7:6], 2));
  endproperty
  a_buf_size: assert property (p_buf_size) else $error("packet buffer size wrong"); // RULE_07

  property p_huge;
    @(posedge core_clk) disable iff (!reset_n)
    tx_start && !st_q.soft_reset && tx_frame.pkt_size > st_q.max_frame |=> st_q.tx_stat[TS_HUGE];
  endproperty
  a_huge: assert property (p_huge) else $error("oversize not flagged"); // RULE_13

  property p_max_col;
    @(posedge core_clk) disable iff (!reset_n)
    st_q.tx_busy && !st_q.soft_reset && !tx_start && tx_collision
      && tx_byte_count <= {10'h000, st_q.cfg_two[5:0]} && st_q.col_cnt >= {1'b0, st_q.cfg_three[3:0]}
      |=> tx_abort && !tx_retry && desc_wb.status[TS_MAX_COL] && desc_wb.status[TS_ABORT];
  endproperty
  a_max_col: assert property (p_max_col) else $error("retry limit not enforced"); // RULE_20

  property p_owner_back;
    @(posedge core_clk) disable iff (!reset_n)
    desc_wb.valid |-> !desc_wb.status[TS_OWNER] && $past(st_q.tx_busy) && !st_q.tx_busy;
  endproperty
  a_owner_back: assert property (p_owner_back) else $error("descriptor returned while owned"); // RULE_21

  property p_irq_level;
    @(posedge core_clk) disable iff (!reset_n)
    irq == (st_q.irq_status != 8'h00);
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("interrupt level disagrees with flags"); // RULE_22

endmodule

// [hdl/emac_status_pkg.sv]
// constants and carrier types for the ethernet descriptor/status block
// assumes byte addressing on the register bus, 32-bit data, one register per word
package emac_status_pkg;

  localparam int unsigned ADDR_W = 6;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_TX_START = 6'h04;
  localparam logic [ADDR_W-1:0] OFS_RX_START = 6'h08;
  localparam logic [ADDR_W-1:0] OFS_RX_LIMIT = 6'h0C;
  localparam logic [ADDR_W-1:0] OFS_BUF_SIZE = 6'h10;
  localparam logic [ADDR_W-1:0] OFS_MAX_FRAME = 6'h14;
  localparam logic [ADDR_W-1:0] OFS_CFG_TWO = 6'h18;
  localparam logic [ADDR_W-1:0] OFS_CFG_THREE = 6'h1C;
  localparam logic [ADDR_W-1:0] OFS_CONTROL = 6'h20;
  localparam logic [ADDR_W-1:0] OFS_TX_STATUS = 6'h24;

  // interrupt status bit positions
  localparam int unsigned IRQ_TX_DONE = 0;
  localparam int unsigned IRQ_TX_CTRL = 1;
  localparam int unsigned IRQ_RX_OVR = 2;
  localparam int unsigned IRQ_RX_DONE = 3;
  localparam int unsigned IRQ_RX_PAUSE = 4;
  localparam int unsigned IRQ_RX_CTRL = 5;
  localparam int unsigned IRQ_MGMT = 6;
  localparam int unsigned IRQ_FSM_FAULT = 7;

  // transmit status word bit positions
  localparam int unsigned TS_OWNER = 15;
  localparam int unsigned TS_ABORT = 14;
  localparam int unsigned TS_BACKPR = 13;
  localparam int unsigned TS_HUGE = 12;
  localparam int unsigned TS_LOOR = 11;
  localparam int unsigned TS_LEN_ERR = 10;
  localparam int unsigned TS_BAD_FCS = 9;
  localparam int unsigned TS_DEFER = 8;
  localparam int unsigned TS_XS_DEFER = 7;
  localparam int unsigned TS_UNDERRUN = 6;
  localparam int unsigned TS_LATE_COL = 5;
  localparam int unsigned TS_MAX_COL = 4;

  // control register bit positions
  localparam int unsigned CTL_FCS_APPEND = 0;
  localparam int unsigned CTL_SPEED_100 = 1;
  localparam int unsigned CTL_UNDERRUN_RETRY = 2;
  localparam int unsigned CTL_TX_RESET = 3;

  // reset values
  localparam logic [23:0] RST_PTR = 24'h00_0000;
  localparam logic [7:0] RST_BUF_SIZE = 8'h00;
  localparam logic [15:0] RST_MAX_FRAME = 16'h05EE;
  localparam logic [7:0] RST_CFG_TWO = 8'h38;
  localparam logic [7:0] RST_CFG_THREE = 8'h0F;
  localparam logic [7:0] RST_CONTROL = 8'h03;

  // frame and timing figures
  localparam logic [8:0] BUF_UNIT_BYTES = 9'h020;
  localparam logic [15:0] MAX_LEN_FIELD = 16'h05EE;
  localparam logic [15:0] MIN_TYPE_FIELD = 16'h0600;
  localparam int unsigned DESC_BYTES = 7;
  localparam int unsigned FCS_BYTES = 4;
  localparam logic [14:0] XS_DEFER_NIBBLES = 15'h17B7;
  localparam logic [14:0] XS_DEFER_BITS = 15'h5EDF;

  typedef struct packed {
    logic [15:0] pkt_size;
    logic [15:0] type_len;
    logic [15:0] data_len;
    logic fcs_ok;
    logic is_ctrl;
    logic [23:0] next_ptr;
  } tx_frame_t;

  typedef struct packed {
    logic fsm_fault;
    logic mgmt_done;
    logic rx_overrun;
    logic rx_done;
    logic rx_ctrl;
    logic rx_pause;
  } mac_events_t;

  typedef struct packed {
    logic valid;
    logic [23:0] next_ptr;
    logic [15:0] status;
  } desc_wb_t;

endpackage

// [dv/mac_side_model.sv]
// transmit-side mac model: starts a packet, then reports line events for it
// assumes the bench calls send() and that it shares core_clk with the block
`timescale 1ns/1ns
module mac_side_model (
  // clock
  input wire logic core_clk,
  // transmit attempt
  output logic tx_start,
  output emac_status_pkg::tx_frame_t tx_frame,
  output logic tx_defer_tick,
  output logic tx_backpressure,
  output logic tx_underrun,
  output logic tx_collision,
  output logic [15:0] tx_byte_count,
  output logic tx_complete
);
  import emac_status_pkg::*;

  initial begin
    tx_start = 1'b0;
    tx_frame = '0;
    tx_defer_tick = 1'b0;
    tx_backpressure = 1'b0;
    tx_underrun = 1'b0;
    tx_collision = 1'b0;
    tx_byte_count = 16'h0000;
    tx_complete = 1'b0;
  end

  // ur bit0 underrun, bit1 back pressure
  task automatic send(input tx_frame_t f, input int nc, input logic [15:0] cb, input int dfr, input int ur);
    @(posedge core_clk);
    tx_start <= 1'b1;
    tx_frame <= f;
    @(posedge core_clk);
    tx_start <= 1'b0;
    // frame is qualified by the start pulse only, so it must not linger
    tx_frame <= ~f;
    if (dfr > 0) begin
      tx_defer_tick <= 1'b1;
      repeat (dfr) @(posedge core_clk);
      tx_defer_tick <= 1'b0;
    end
    repeat (nc) begin
      @(posedge core_clk);
      tx_collision <= 1'b1;
      tx_byte_count <= cb;
      @(posedge core_clk);
      tx_collision <= 1'b0;
      tx_byte_count <= ~cb;
      repeat (2) @(posedge core_clk);
    end
    @(posedge core_clk);
    tx_underrun <= ur[0];
    tx_backpressure <= ur[1];
    @(posedge core_clk);
    tx_underrun <= 1'b0;
    tx_backpressure <= 1'b0;
    @(posedge core_clk);
    tx_complete <= 1'b1;
    @(posedge core_clk);
    tx_complete <= 1'b0;
  endtask
endmodule

// [dv/emac_status_tb.sv]
// self-checking bench for the descriptor status and interrupt flag block
// assumes the transmit-side model in dv/ and byte enables always full
`timescale 1ns/1ns
module emac_status_tb;
  import emac_status_pkg::*;
  logic core_clk, reset_n, avs_read, avs_write, avs_waitrequest;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  mac_events_t mac_events;
  logic tx_start, tx_defer_tick, tx_backpressure, tx_underrun, tx_collision, tx_complete;
  logic tx_retry, tx_abort, tx_soft_reset, fcs_append_enable, rx_discard, irq;
  logic [15:0] tx_byte_count;
  tx_frame_t tx_frame;
  desc_wb_t desc_wb, wb_q;
  logic [23:0] transmit_region_start, receive_region_start, receive_region_limit;
  logic [23:0] p[3];
  logic [8:0] pkt_buf_bytes;
  logic [31:0] rs = 32'h62c0_b8f4;
  int fails, check_count, wb_n, rt_n, ab_n, sr_n, irq_m, ln, maxf = 1518, lim = 15, app = 1, urr = 0;
  logic [ADDR_W-1:0] ofs[10] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10, 6'h14, 6'h18, 6'h1C, 6'h20, 6'h3C};
  logic [31:0] rv[10] = '{0, 0, 0, 0, 0, 32'h0000_05EE, 32'h0000_0038, 32'h0000_000F, 32'h0000_0003, 0};
  mac_events_t evs[6] = '{6'b10_0000, 6'b01_0000, 6'b00_0100, 6'b00_0110, 6'b00_0101, 6'b00_1000};
  logic [7:0] ievs[6] = '{8'h80, 8'h40, 8'h08, 8'h28, 8'h18, 8'h04};

  emac_status dut (.core_clk, .reset_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .mac_events, .tx_start, .tx_frame, .tx_defer_tick,
    .tx_backpressure, .tx_underrun, .tx_collision, .tx_byte_count, .tx_complete, .tx_retry, .tx_abort,
    .tx_soft_reset, .desc_wb, .transmit_region_start, .receive_region_start, .receive_region_limit,
    .pkt_buf_bytes, .fcs_append_enable, .rx_discard, .irq);
  mac_side_model mac (.core_clk, .tx_start, .tx_frame, .tx_defer_tick, .tx_backpressure, .tx_underrun,
    .tx_collision, .tx_byte_count, .tx_complete);

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // pulses are sampled mid-cycle, away from the edge that launches them
  always @(negedge core_clk) begin
    if (desc_wb.valid === 1'b1) begin
      wb_n++;
      wb_q = desc_wb;
    end
    if (tx_retry === 1'b1) rt_n++;
    if (tx_abort === 1'b1) ab_n++;
    if (tx_soft_reset === 1'b1) sr_n++;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    // waitrequest and read data are both taken at the edge that ends the wait
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      fails++;
      wrap_up;
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic settle;
    repeat (2) @(negedge core_clk);
  endtask

  task automatic ev(input mac_events_t e);
    @(posedge core_clk);
    mac_events <= e;
    @(posedge core_clk);
    mac_events <= '0;
  endtask

  function automatic tx_frame_t mkf(input int len, input int tl, input logic ok, input logic ctl);
    tx_frame_t f;
    rs = lfsr(rs);
    f.data_len = 16'(len);
    f.pkt_size = 16'(len + 18);
    f.type_len = 16'(tl);
    f.fcs_ok = ok;
    f.is_ctrl = ctl;
    f.next_ptr = rs[23:0];
    return f;
  endfunction

  function automatic logic [15:0] model(input tx_frame_t f, input int nc, input int cb, input int dfr, input int ur);
    int s;
    s = 0;
    if (f.pkt_size > maxf) s |= 16'h1000;
    if (f.type_len > 1518 && f.type_len < 1536) s |= 16'h0800;
    if (f.type_len <= 1518 && f.type_len != f.data_len) s |= 16'h0400;
    if (app == 0 && !f.fcs_ok) s |= 16'h0200;
    if (dfr > 0) s |= 16'h0100;
    if (dfr > 6071) s |= 16'h0080;
    if (ur[0]) s |= urr ? 16'h0040 : 16'h4040;
    if (ur[1]) s |= 16'h2000;
    if (cb > 'h38) s |= 16'h4020;
    else s |= (nc > lim) ? (16'h4010 | (lim + 1)) : nc;
    return s[15:0];
  endfunction

  task automatic tx(input tx_frame_t f, input int nc, input int cb, input int dfr, input int ur,
                    input logic [15:0] m, input int ix);
    int n0, r0, a0, k;
    logic [15:0] e;
    n0 = wb_n;
    r0 = rt_n;
    a0 = ab_n;
    k = 0;
    e = model(f, nc, cb, dfr, ur);
    mac.send(f, nc, cb[15:0], dfr, ur);
    while (wb_n == n0 && k < 40) begin
      @(posedge core_clk);
      k++;
    end
    if (wb_n == n0) begin
      fails++;
      wrap_up;
    end
    repeat (3) @(posedge core_clk);
    chk(wb_n - n0, 1);
    chk(wb_q.status & m, e & m);
    chk(wb_q.next_ptr, f.next_ptr);
    chk(rt_n - r0, (cb > 'h38 ? 0 : (nc > lim ? lim : nc)) + (ur[0] ? urr : 0));
    if (m[14]) chk(ab_n - a0, e[14]);
    bus(0, OFS_IRQ_STATUS, 0);
    if (ix >= 0) chk(rd, ix);
    bus(1, OFS_IRQ_STATUS, 32'h0000_00FF);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    fails++;
    wrap_up;
  end

  initial begin
    reset_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    mac_events = '0;
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    chk(pkt_buf_bytes, 32);
    chk(irq, 0);
    foreach (ofs[i]) begin bus(0, ofs[i], 0); chk(rd, rv[i]); end
    $display("reset values done");
    for (int i = 0; i < 3; i++) begin
      rs = lfsr(rs);
      p[i] = rs[23:0];
      bus(1, ofs[i + 1], {8'h00, p[i]});
    end
    settle;
    chk(transmit_region_start, p[0]);
    chk(receive_region_start, p[1]);
    chk(receive_region_limit, p[2]);
    for (int i = 0; i < 4; i++) begin
      bus(1, OFS_BUF_SIZE, 32'(i << 6));
      settle;
      chk(pkt_buf_bytes, 32 << i);
    end
    $display("partition done");
    for (int i = 0; i < 6; i++) begin
      ev(evs[i]);
      irq_m = ievs[i];
      settle;
      chk(irq, 1);
      chk(rx_discard, i == 5);
      if (i == 5) ev(6'b00_0100);
      bus(0, OFS_IRQ_STATUS, 0);
      chk(rd, irq_m);
      bus(1, OFS_IRQ_STATUS, irq_m);
      settle;
      chk({irq, rx_discard}, 0);
    end
    bus(1, OFS_CONTROL, 32'h0000_000B);
    settle;
    chk(sr_n, 1);
    $display("event flags done");
    rs = lfsr(rs);
    ln = 46 + int'(rs[9:0]);
    tx(mkf(ln, ln, 1, 0), 0, 0, 0, 0, 16'hFFFF, 1);
    tx(mkf(ln, 16'h8808, 1, 1), 0, 0, 0, 0, 16'hFFFF, 2);
    tx(mkf(ln, ln, 1, 0), 2, 16, 0, 0, 16'hFFFF, -1);
    tx(mkf(ln, ln, 1, 0), 1, 57, 0, 0, 16'hFFFF, -1);
    tx(mkf(1501, 1501, 1, 0), 0, 0, 0, 0, 16'hFFFF, -1);
    tx(mkf(ln, 1519, 1, 0), 0, 0, 0, 0, 16'hFFFF, -1);
    tx(mkf(ln, ln + 1, 1, 0), 0, 0, 0, 0, 16'hFFFF, -1);
    tx(mkf(ln, ln, 0, 0), 0, 0, 0, 0, 16'hFFFF, -1);
    tx(mkf(ln, ln, 1, 0), 0, 0, 0, 3, 16'hFFFF, -1);
    tx(mkf(ln, ln, 1, 0), 0, 0, 6071, 0, 16'hBFFF, -1);
    tx(mkf(ln, ln, 1, 0), 0, 0, 6072, 0, 16'hBFFF, -1);
    bus(1, OFS_CONTROL, 32'h0000_0002);
    app = 0;
    settle;
    chk(fcs_append_enable, 0);
    tx(mkf(ln, ln, 0, 0), 0, 0, 0, 0, 16'hFFFF, -1);
    bus(1, OFS_CONTROL, 32'h0000_0006);
    urr = 1;
    tx(mkf(ln, ln, 1, 0), 0, 0, 0, 1, 16'hFFFF, 1);
    bus(1, OFS_CFG_THREE, 32'h0000_0001);
    lim = 1;
    tx(mkf(ln, ln, 1, 0), 2, 16, 0, 0, 16'hFFFF, -1);
    $display("transmit status done");
    wrap_up;
  end
endmodule
